/* File: pkg/rfcsr_pkg.sv */
package rfcsr_pkg;
   // ---------------------------------------------------------------
   // Register indices and byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] TX_CLOCK_CONTROL_IDX = 8'h21;
   localparam logic [7:0] RX_CONTROL_IDX       = 8'h22;
   localparam logic [7:0] LEVEL_DETECTOR_IDX   = 8'h23;
   localparam logic [7:0] SYSTEM_STATUS_IDX    = 8'h24;
   localparam logic [9:0] TX_CLOCK_CONTROL_ADDR = {TX_CLOCK_CONTROL_IDX, 2'b00};
   localparam logic [9:0] RX_CONTROL_ADDR       = {RX_CONTROL_IDX, 2'b00};
   localparam logic [9:0] LEVEL_DETECTOR_ADDR   = {LEVEL_DETECTOR_IDX, 2'b00};
   localparam logic [9:0] SYSTEM_STATUS_ADDR    = {SYSTEM_STATUS_IDX, 2'b00};

   // ---------------------------------------------------------------
   // Writable masks and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] TX_CLOCK_WMASK = 32'h00043fff;
   localparam logic [31:0] RX_WMASK       = 32'h000000ff;
   localparam logic [31:0] LD_WMASK       = 32'h00007fff;
   localparam logic [31:0] RESET_VALUE    = 32'h00000000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ALM_ON_BIT       = 18;
   localparam int PHASE_LSB        = 11;
   localparam int GUARD_MODE_LSB   = 8;
   localparam int D2_INV_RD_BIT    = 7;
   localparam int D2_INV_CD_BIT    = 6;
   localparam int D1_INV_RD_BIT    = 5;
   localparam int D1_INV_CD_BIT    = 4;
   localparam int READER_MODE_LSB  = 1;
   localparam int PHASE_LOOP_BIT   = 0;
   localparam int DEMOD_REF_LSB    = 6;
   localparam int MIXER_LSB        = 4;
   localparam int HPC_LSB          = 2;
   localparam int GAIN_LSB         = 0;
   localparam int NF_OFF_BIT       = 14;
   localparam int FD_SRC_LSB       = 12;
   localparam int NF_THR_LSB       = 8;
   localparam int LD_REF_A_LSB     = 4;
   localparam int LD_REF_B_LSB     = 0;

   // Rate codes: two lower and two higher bit rates
   localparam logic [1:0] RATE_106 = 2'h0;
   localparam logic [1:0] RATE_212 = 2'h1;
   localparam logic [1:0] RATE_424 = 2'h2;
   localparam logic [1:0] RATE_848 = 2'h3;

   // AHB transfer types and word size
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

/* File: logic/rfcsr_regs.sv */
module rfcsr_regs (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [1:0]  bitRate,
   input  wire logic        guardActive,
   input  wire logic        cardMode,
   input  wire logic        clkTrue,
   input  wire logic        nearFieldHit,
   input  wire logic        levelHit,
   input  wire logic        rxEvent,
   input  wire logic [3:0]  minimumReceiveLevel,
   input  wire logic        regulatorOutputGood,
   input  wire logic [2:0]  hostErrors,
   input  wire logic        standbyBlockedByField,
   input  wire logic [4:0]  bootCause,
   output logic [4:0]       residualNormal,
   output logic [4:0]       residualGuard,
   input  wire logic [4:0]  residualCfgNormal,
   input  wire logic [4:0]  residualCfgGuard,
   output logic             activeLoadModOn,
   output logic [2:0]       recoveredClockPhaseStep,
   output logic [2:0]       driverMode,
   output logic             driver1Clk,
   output logic             driver2Clk,
   output logic             phaseLoopOn,
   output logic [1:0]       cardDemodRefLevel,
   output logic             readerMixerOn,
   output logic             cardMixerOn,
   output logic [1:0]       highpassCornerSelect,
   output logic [1:0]       basebandGain,
   output logic             rxIrqRequest,
   output logic             nearFieldDetectorOff,
   output logic [3:0]       nearFieldThreshold,
   output logic [3:0]       levelDetectorRefA,
   output logic [3:0]       levelDetectorRefB,
   output logic             fieldPresent
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        dPend;
      logic        dWrite;
      logic [9:0]  dAddr;
      logic [31:0] txClk;
      logic [31:0] rx;
      logic [31:0] ld;
      logic [9:0]  status;
      logic [31:0] rdata;
      logic [4:0]  resN;
      logic [4:0]  resG;
      logic [2:0]  drvMode;
      logic        drv1;
      logic        drv2;
      logic        mixR;
      logic        mixC;
      logic        irq;
      logic        field;
   } rfcsr_state_type;

   rfcsr_state_type st;
   rfcsr_state_type next_st;

   logic addrPhase;
   logic highRate;
   logic inv1;
   logic inv2;

   assign addrPhase = hsel && hready && htrans[1];
   assign highRate  = (bitRate == rfcsr_pkg::RATE_424) || (bitRate == rfcsr_pkg::RATE_848);

   always_comb begin
      next_st = st;
      // ---------------------------------------------------------------
      // Bus data phase: one wait-free cycle, write lands at data phase
      // ---------------------------------------------------------------
      if (st.dPend && st.dWrite) begin
         if (st.dAddr == rfcsr_pkg::TX_CLOCK_CONTROL_ADDR) begin
            next_st.txClk = hwdata & rfcsr_pkg::TX_CLOCK_WMASK;
         end else if (st.dAddr == rfcsr_pkg::RX_CONTROL_ADDR) begin
            next_st.rx = hwdata & rfcsr_pkg::RX_WMASK;
         end else if (st.dAddr == rfcsr_pkg::LEVEL_DETECTOR_ADDR) begin
            next_st.ld = hwdata & rfcsr_pkg::LD_WMASK;
         end
      end
      next_st.dPend  = addrPhase;
      next_st.dWrite = hwrite;
      next_st.dAddr  = haddr[9:0];
      // Read data is captured in the address phase so it stands in the data phase
      next_st.rdata = 32'h00000000;
      if (addrPhase && !hwrite) begin
         if (haddr[9:0] == rfcsr_pkg::TX_CLOCK_CONTROL_ADDR) begin
            next_st.rdata = next_st.txClk;
         end else if (haddr[9:0] == rfcsr_pkg::RX_CONTROL_ADDR) begin
            next_st.rdata = next_st.rx;
         end else if (haddr[9:0] == rfcsr_pkg::LEVEL_DETECTOR_ADDR) begin
            next_st.rdata = next_st.ld;
         end else if (haddr[9:0] == rfcsr_pkg::SYSTEM_STATUS_ADDR) begin
            next_st.rdata = {22'h000000, st.status};
         end
      end
      // ---------------------------------------------------------------
      // Status word, sampled every cycle
      // ---------------------------------------------------------------
      next_st.status = {regulatorOutputGood, hostErrors, standbyBlockedByField,
                        bootCause};
      // ---------------------------------------------------------------
      // Transmit steering
      // ---------------------------------------------------------------
      if (highRate) begin
         next_st.resN = residualCfgGuard;
         next_st.resG = residualCfgNormal;
      end else begin
         next_st.resN = residualCfgNormal;
         next_st.resG = residualCfgGuard;
      end
      next_st.drvMode = guardActive
                        ? st.txClk[rfcsr_pkg::GUARD_MODE_LSB +: 3]
                        : st.txClk[rfcsr_pkg::READER_MODE_LSB +: 3];
      next_st.drv1 = clkTrue ^ inv1;
      next_st.drv2 = clkTrue ^ inv2;
      // ---------------------------------------------------------------
      // Receive steering
      // ---------------------------------------------------------------
      next_st.mixR = (st.rx[rfcsr_pkg::MIXER_LSB +: 2] == 2'h1);
      next_st.mixC = (st.rx[rfcsr_pkg::MIXER_LSB +: 2] == 2'h2);
      // Gain at maximum with lowest level blinds the receiver interrupt
      next_st.irq = rxEvent && !((st.rx[rfcsr_pkg::GAIN_LSB +: 2] == 2'h3)
                                 && (minimumReceiveLevel == 4'h0));
      // ---------------------------------------------------------------
      // Field presence
      // ---------------------------------------------------------------
      case (st.ld[rfcsr_pkg::FD_SRC_LSB +: 2])
         2'h0: next_st.field = nearFieldHit && !st.ld[rfcsr_pkg::NF_OFF_BIT];
         2'h1: next_st.field = levelHit;
         2'h2: next_st.field = (nearFieldHit && !st.ld[rfcsr_pkg::NF_OFF_BIT])
                               || levelHit;
         default: next_st.field = 1'b1;
      endcase
   end

   assign inv1 = cardMode ? st.txClk[rfcsr_pkg::D1_INV_CD_BIT] : st.txClk[rfcsr_pkg::D1_INV_RD_BIT];
   assign inv2 = cardMode ? st.txClk[rfcsr_pkg::D2_INV_CD_BIT] : st.txClk[rfcsr_pkg::D2_INV_RD_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hrdata                  = st.rdata;
   assign hreadyout               = 1'b1;
   assign hresp                   = 1'b0;
   assign residualNormal          = st.resN;
   assign residualGuard           = st.resG;
   assign activeLoadModOn         = st.txClk[rfcsr_pkg::ALM_ON_BIT];
   assign recoveredClockPhaseStep = st.txClk[rfcsr_pkg::PHASE_LSB +: 3];
   assign driverMode              = st.drvMode;
   assign driver1Clk              = st.drv1;
   assign driver2Clk              = st.drv2;
   assign phaseLoopOn             = st.txClk[rfcsr_pkg::PHASE_LOOP_BIT];
   assign cardDemodRefLevel       = st.rx[rfcsr_pkg::DEMOD_REF_LSB +: 2];
   assign readerMixerOn           = st.mixR;
   assign cardMixerOn             = st.mixC;
   assign highpassCornerSelect    = st.rx[rfcsr_pkg::HPC_LSB +: 2];
   assign basebandGain            = st.rx[rfcsr_pkg::GAIN_LSB +: 2];
   assign rxIrqRequest            = st.irq;
   assign nearFieldDetectorOff    = st.ld[rfcsr_pkg::NF_OFF_BIT];
   assign nearFieldThreshold      = st.ld[rfcsr_pkg::NF_THR_LSB +: 4];
   assign levelDetectorRefA       = st.ld[rfcsr_pkg::LD_REF_A_LSB +: 4];
   assign levelDetectorRefB       = st.ld[rfcsr_pkg::LD_REF_B_LSB +: 4];
   assign fieldPresent            = st.field;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence txWriteSeq;
      addrPhase && hwrite && (haddr[9:0] == rfcsr_pkg::TX_CLOCK_CONTROL_ADDR);
   endsequence

   residual_swap_a: assert property (@(posedge clk) disable iff (rst)
      highRate |=> (residualNormal == $past(residualCfgGuard)))
      else $error("residual levels not swapped at high rate");
   alm_write_a: assert property (@(posedge clk) disable iff (rst)
      txWriteSeq ##1 1'b1 |=> (activeLoadModOn == $past(hwdata[18])))
      else $error("active load modulation bit not written");
   phase_field_a: assert property (@(posedge clk) disable iff (rst)
      txWriteSeq ##1 1'b1 |=> (recoveredClockPhaseStep == $past(hwdata[13:11])))
      else $error("phase step field wrong");
   guard_mode_a: assert property (@(posedge clk) disable iff (rst)
      guardActive |=> (driverMode == $past(st.txClk[10:8])))
      else $error("guard driver mode wrong");
   invert_card_a: assert property (@(posedge clk) disable iff (rst)
      cardMode |=> (driver1Clk == ($past(clkTrue) ^ $past(st.txClk[4]))))
      else $error("card inversion wrong");
   mixer_excl_a: assert property (@(posedge clk) disable iff (rst)
      !(readerMixerOn && cardMixerOn))
      else $error("both mixers on");
   irq_block_a: assert property (@(posedge clk) disable iff (rst)
      (basebandGain == 2'h3 && minimumReceiveLevel == 4'h0) |=> !rxIrqRequest)
      else $error("interrupt raised in blind combination");
   field_force_a: assert property (@(posedge clk) disable iff (rst)
      (st.ld[13:12] == 2'h3) |=> fieldPresent)
      else $error("forced field not present");
   residual_keep_a: assert property (@(posedge clk) disable iff (rst)
      !highRate |=> (residualNormal == $past(residualCfgNormal)))
      else $error("residual levels swapped at low rate");
   reader_mode_a: assert property (@(posedge clk) disable iff (rst)
      !guardActive |=> (driverMode == $past(st.txClk[3:1])))
      else $error("reader driver mode wrong");
   invert_reader_a: assert property (@(posedge clk) disable iff (rst)
      !cardMode |=> (driver2Clk == ($past(clkTrue) ^ $past(st.txClk[7]))))
      else $error("reader inversion wrong");
   mixer_reader_a: assert property (@(posedge clk) disable iff (rst)
      (st.rx[5:4] == 2'h1) |=> (readerMixerOn && !cardMixerOn))
      else $error("reader mixer not selected");
   mixer_card_a: assert property (@(posedge clk) disable iff (rst)
      (st.rx[5:4] == 2'h2) |=> (cardMixerOn && !readerMixerOn))
      else $error("card mixer not selected");
   near_off_a: assert property (@(posedge clk) disable iff (rst)
      (st.ld[13:12] == 2'h0 && st.ld[14]) |=> !fieldPresent)
      else $error("powered-down detector reports field");
   status_bits_a: assert property (@(posedge clk) disable iff (rst)
      addrPhase && !hwrite && haddr[9:0] == rfcsr_pkg::SYSTEM_STATUS_ADDR
      |=> hrdata[9:0] == $past(st.status))
      else $error("status bits not returned");
   status_read_a: assert property (@(posedge clk) disable iff (rst)
      addrPhase && !hwrite && haddr[9:0] == rfcsr_pkg::SYSTEM_STATUS_ADDR
      |=> hrdata[31:10] == 22'h000000)
      else $error("status reserved bits not zero");
endmodule

/* File: test/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Signals and design
   // ---------------------------------------------------------------
   logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, bitRate, cardDemodRefLevel, highpassCornerSelect, basebandGain;
   logic [2:0]  hsize, hostErrors, recoveredClockPhaseStep, driverMode;
   logic        guardActive, cardMode, clkTrue, nearFieldHit, levelHit, rxEvent;
   logic [3:0]  minimumReceiveLevel, nearFieldThreshold, levelDetectorRefA, levelDetectorRefB;
   logic        regulatorOutputGood, standbyBlockedByField, activeLoadModOn, phaseLoopOn;
   logic [4:0]  bootCause, residualNormal, residualGuard, residualCfgNormal, residualCfgGuard;
   logic        driver1Clk, driver2Clk, readerMixerOn, cardMixerOn, rxIrqRequest;
   logic        nearFieldDetectorOff, fieldPresent;
   logic [31:0] txShadow, rxShadow, ldShadow, seed, rdData, curAddr;
   logic [31:0] addrList [0:5];
   int          errCount, totalChecks;
   assign hready = hreadyout;
   rfcsr_regs i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .bitRate(bitRate), .guardActive(guardActive),
      .cardMode(cardMode), .clkTrue(clkTrue), .nearFieldHit(nearFieldHit), .levelHit(levelHit),
      .rxEvent(rxEvent), .minimumReceiveLevel(minimumReceiveLevel),
      .regulatorOutputGood(regulatorOutputGood), .hostErrors(hostErrors),
      .standbyBlockedByField(standbyBlockedByField), .bootCause(bootCause),
      .residualNormal(residualNormal), .residualGuard(residualGuard),
      .residualCfgNormal(residualCfgNormal), .residualCfgGuard(residualCfgGuard),
      .activeLoadModOn(activeLoadModOn), .recoveredClockPhaseStep(recoveredClockPhaseStep),
      .driverMode(driverMode), .driver1Clk(driver1Clk), .driver2Clk(driver2Clk),
      .phaseLoopOn(phaseLoopOn), .cardDemodRefLevel(cardDemodRefLevel),
      .readerMixerOn(readerMixerOn), .cardMixerOn(cardMixerOn),
      .highpassCornerSelect(highpassCornerSelect), .basebandGain(basebandGain),
      .rxIrqRequest(rxIrqRequest), .nearFieldDetectorOff(nearFieldDetectorOff),
      .nearFieldThreshold(nearFieldThreshold), .levelDetectorRefA(levelDetectorRefA),
      .levelDetectorRefB(levelDetectorRefB), .fieldPresent(fieldPresent));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   function automatic logic [31:0] expRead(input logic [31:0] a);
      if (a == addrList[0]) return txShadow;
      if (a == addrList[1]) return rxShadow;
      if (a == addrList[2]) return ldShadow;
      if (a == addrList[3]) return {22'h000000, regulatorOutputGood, hostErrors,
                                    standbyBlockedByField, bootCause};
      return 32'h00000000;
   endfunction
   // Near indication is masked while the near detector is powered down
   function automatic logic expField();
      logic nearOk;
      nearOk = nearFieldHit && !ldShadow[14];
      case (ldShadow[13:12])
         2'h0: return nearOk;
         2'h1: return levelHit;
         2'h2: return nearOk || levelHit;
         default: return 1'b1;
      endcase
   endfunction
   task automatic finalReport();
      $display("checks %0d mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Every bus task starts and ends just after a rising edge, so transfers chain back to back
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         errCount++;
         $display("wrong value at %0t: bus wait ran out", $time);
         finalReport();
      end
   endtask
   task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= rfcsr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= rfcsr_pkg::HSIZE_WORD;
      waitReady();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wr ? d : 32'h00000000;
      waitReady();
      rdData = hrdata;
      if (wr && a == addrList[0]) txShadow = d & rfcsr_pkg::TX_CLOCK_WMASK;
      if (wr && a == addrList[1]) rxShadow = d & rfcsr_pkg::RX_WMASK;
      if (wr && a == addrList[2]) ldShadow = d & rfcsr_pkg::LD_WMASK;
   endtask
   task automatic readCheck(input logic [31:0] a);
      busXfer(1'b0, a, 32'h00000000);
      check(rdData, expRead(a));
      check(32'(hresp), 32'h00000000);
   endtask
   task automatic checkFields();
      check(32'(activeLoadModOn), 32'(txShadow[18]));
      check(32'(recoveredClockPhaseStep), 32'(txShadow[13:11]));
      check(32'(phaseLoopOn), 32'(txShadow[0]));
      check(32'({cardDemodRefLevel, highpassCornerSelect, basebandGain}),
            32'({rxShadow[7:6], rxShadow[3:0]}));
      check(32'({nearFieldDetectorOff, nearFieldThreshold, levelDetectorRefA,
                 levelDetectorRefB}), 32'({ldShadow[14], ldShadow[11:0]}));
   endtask
   task automatic sideCycle(input logic corner);
      logic [31:0] r;
      logic        inv1, inv2;
      seed = lfsr(seed);
      r = seed;
      {bitRate, guardActive, cardMode, clkTrue, nearFieldHit, levelHit} <= r[6:0];
      rxEvent <= r[7] | corner;
      minimumReceiveLevel <= corner ? 4'h0 : r[11:8];
      {regulatorOutputGood, hostErrors, standbyBlockedByField, bootCause} <= r[21:12];
      {residualCfgNormal, residualCfgGuard} <= r[31:22];
      @(posedge clk);
      #1;
      check(32'(driverMode), 32'(guardActive ? txShadow[10:8] : txShadow[3:1]));
      inv1 = cardMode ? txShadow[4] : txShadow[5];
      inv2 = cardMode ? txShadow[6] : txShadow[7];
      check(32'({driver2Clk, driver1Clk}), 32'({clkTrue ^ inv2, clkTrue ^ inv1}));
      check(32'({readerMixerOn, cardMixerOn}),
            32'({rxShadow[5:4] == 2'h1, rxShadow[5:4] == 2'h2}));
      check(32'({residualNormal, residualGuard}), bitRate[1] ?
            32'({residualCfgGuard, residualCfgNormal}) :
            32'({residualCfgNormal, residualCfgGuard}));
      check(32'(rxIrqRequest), 32'(rxEvent &&
            !(rxShadow[1:0] == 2'h3 && minimumReceiveLevel == 4'h0)));
      check(32'(fieldPresent), 32'(expField()));
      @(posedge clk);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, hsel, hwrite, haddr, htrans, hsize, hwdata} = {1'b1, 71'h0};
      {bitRate, guardActive, cardMode, clkTrue, nearFieldHit, levelHit, rxEvent} = 8'h00;
      {minimumReceiveLevel, regulatorOutputGood, hostErrors, standbyBlockedByField} = 9'h000;
      {bootCause, residualCfgNormal, residualCfgGuard} = 15'h0000;
      {txShadow, rxShadow, ldShadow, errCount, totalChecks} = '0;
      seed = 32'h00002757;
      addrList[0] = 32'(rfcsr_pkg::TX_CLOCK_CONTROL_ADDR);
      addrList[1] = 32'(rfcsr_pkg::RX_CONTROL_ADDR);
      addrList[2] = 32'(rfcsr_pkg::LEVEL_DETECTOR_ADDR);
      addrList[3] = 32'(rfcsr_pkg::SYSTEM_STATUS_ADDR);
      addrList[4] = 32'h00000094;
      addrList[5] = 32'h00000080;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) readCheck(addrList[i]);
      checkFields();
      $display("test reset values done");
      // Write then read at once, unmapped and read-only places included
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         curAddr = addrList[int'(seed % 32'h6)];
         seed = lfsr(seed);
         busXfer(1'b1, curAddr, seed);
         readCheck(curAddr);
         checkFields();
      end
      $display("test register access done");
      // Every mixer code and field source, gain 3 with lowest level on odd passes
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         busXfer(1'b1, addrList[0], seed);
         seed = lfsr(seed);
         busXfer(1'b1, addrList[1], {seed[31:6], i[1:0], seed[3:2], i[0] ? 2'h3 : seed[1:0]});
         seed = lfsr(seed);
         busXfer(1'b1, addrList[2], {seed[31:14], i[3:2], seed[11:0]});
         repeat (8) sideCycle(i[0]);
         readCheck(addrList[3]);
      end
      $display("test field behaviour done");
      // Quiet steering and residual inputs across the reset; status inputs keep their last random levels, minimumReceiveLevel stays at 4'h0
      {bitRate, guardActive, cardMode, clkTrue, nearFieldHit, levelHit, rxEvent} <= 8'h00;
      {residualCfgNormal, residualCfgGuard} <= 10'h000;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      {txShadow, rxShadow, ldShadow} = '0;
      for (int i = 0; i < 6; i++) readCheck(addrList[i]);
      checkFields();
      $display("test second reset done");
      finalReport();
   end
endmodule
